// ==== include/fprnu_pkg.sv ====
package fprnu_pkg;

    // ------------------------------------------------------------
    // Number formats
    // ------------------------------------------------------------
    typedef struct packed {
        logic sign;
        logic [7:0] exp;
        logic [22:0] frac;
    } fprnu_sp_t;

    typedef struct packed {
        logic sign;
        logic [4:0] exp;
        logic [9:0] frac;
    } fprnu_hp_t;

    localparam int FPRNU_SP_SIG_W = 24;
    localparam int FPRNU_HP_SIG_W = 11;
    localparam int FPRNU_SP_QUIET_BIT = 22;
    localparam logic [7:0] FPRNU_SP_EXP_MAX = 8'hff;
    localparam logic [4:0] FPRNU_HP_EXP_MAX = 5'h1f;
    localparam logic [7:0] FPRNU_EXP_REBIAS = 8'h70;
    localparam logic [31:0] FPRNU_SP_QUIET_MASK = 32'h0040_0000;
    localparam logic [9:0] FPRNU_HP_QUIET_MASK = 10'h200;

    // Indefinite: negative quiet NaN with an empty payload
    localparam logic [31:0] FPRNU_INDEF_SP = 32'hffc0_0000;
    localparam logic [63:0] FPRNU_INDEF_DP = 64'hfff8_0000_0000_0000;
    localparam logic [79:0] FPRNU_INDEF_EP = 80'hffff_c000_0000_0000_0000;

    // ------------------------------------------------------------
    // Rounding control codes and commands
    // ------------------------------------------------------------
    localparam logic [1:0] FPRNU_RND_NEAREST = 2'h0;
    localparam logic [1:0] FPRNU_RND_DOWN = 2'h1;
    localparam logic [1:0] FPRNU_RND_UP = 2'h2;
    localparam logic [1:0] FPRNU_RND_TRUNC = 2'h3;

    localparam logic [2:0] FPRNU_OP_ROUND = 3'h0;
    localparam logic [2:0] FPRNU_OP_CMP = 3'h1;
    localparam logic [2:0] FPRNU_OP_H2S = 3'h2;
    localparam logic [2:0] FPRNU_OP_S2H = 3'h3;
    localparam logic [2:0] FPRNU_OP_PROP = 3'h4;

    localparam logic [1:0] FPRNU_FMT_SP = 2'h0;
    localparam logic [1:0] FPRNU_FMT_DP = 2'h1;
    localparam logic [1:0] FPRNU_FMT_EP = 2'h2;

    localparam logic [1:0] FPRNU_CMP_EQ = 2'h0;
    localparam logic [1:0] FPRNU_CMP_LT = 2'h1;
    localparam logic [1:0] FPRNU_CMP_GT = 2'h2;
    localparam logic [1:0] FPRNU_CMP_UN = 2'h3;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] FPRNU_ADDR_CTRL = 8'h00;
    localparam logic [7:0] FPRNU_ADDR_STAT = 8'h04;
    localparam logic [7:0] FPRNU_ADDR_CMD = 8'h08;
    localparam logic [7:0] FPRNU_ADDR_OPA = 8'h0c;
    localparam logic [7:0] FPRNU_ADDR_OPB = 8'h10;
    localparam logic [7:0] FPRNU_ADDR_OPA_PTR = 8'h14;
    localparam logic [7:0] FPRNU_ADDR_OPB_PTR = 8'h18;
    localparam logic [7:0] FPRNU_ADDR_XSE = 8'h1c;
    localparam logic [7:0] FPRNU_ADDR_XSIG = 8'h20;
    localparam logic [7:0] FPRNU_ADDR_RES0 = 8'h24;
    localparam logic [7:0] FPRNU_ADDR_RES1 = 8'h28;
    localparam logic [7:0] FPRNU_ADDR_RES2 = 8'h2c;
    localparam logic [7:0] FPRNU_ADDR_EXC_PTR = 8'h30;

    localparam int FPRNU_CTRL_RND_LSB = 13;
    localparam int FPRNU_CTRL_INV_MASK = 7;
    localparam int FPRNU_STAT_INV = 0;
    localparam int FPRNU_STAT_INEXACT = 5;
    localparam int FPRNU_CMD_FMT_LSB = 4;
    localparam logic [1:0] FPRNU_RESET_RND = 2'h0;
    localparam logic FPRNU_RESET_INV_MASK = 1'b1;

    function automatic logic fprnu_sp_nan(input fprnu_sp_t x);
        return (x.exp == FPRNU_SP_EXP_MAX) && (x.frac != 23'h0);
    endfunction : fprnu_sp_nan

    function automatic logic fprnu_sp_snan(input fprnu_sp_t x);
        return fprnu_sp_nan(x) && !x.frac[FPRNU_SP_QUIET_BIT];
    endfunction : fprnu_sp_snan

endpackage : fprnu_pkg

// ==== src/fprnu_round.sv ====
`timescale 1ns/1ns
module fprnu_round #(
    parameter int W = 24
) (
    input wire logic [W-1:0] sig_in,
    input wire logic guard,
    input wire logic sticky,
    input wire logic sign,
    input wire logic [1:0] mode,
    output logic [W:0] sig_out,
    output logic inexact
);
    logic inc;
    wire logic lost = guard | sticky;

    // Lower bracket is sig_in, upper is sig_in + 1; pick one
    always_comb begin
        unique case (mode)
            fprnu_pkg::FPRNU_RND_NEAREST: inc = guard & (sticky | sig_in[0]);
            fprnu_pkg::FPRNU_RND_DOWN: inc = lost & sign;
            fprnu_pkg::FPRNU_RND_UP: inc = lost & ~sign;
            fprnu_pkg::FPRNU_RND_TRUNC: inc = 1'b0;
        endcase
    end

    // Error stays below one unit of the kept lsb
    assign sig_out = {1'b0, sig_in} + {{W{1'b0}}, inc};
    assign inexact = lost;

endmodule : fprnu_round

// ==== src/fprnu_top.sv ====
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
module fprnu_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fp_trap
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [1:0] rnd_mode;
    logic inv_mask;
    logic inv_flag;
    logic inexact_flag;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opa_addr;
    logic [31:0] opb_addr;
    logic [8:0] exact_se;
    logic [31:0] exact_sig;
    logic [79:0] res;
    logic [31:0] exc_ptr;
    logic [79:0] next_res;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic acc = psel & penable;
    wire logic wr = acc & pwrite;
    wire logic hit_ctrl = paddr == fprnu_pkg::FPRNU_ADDR_CTRL;
    wire logic hit_stat = paddr == fprnu_pkg::FPRNU_ADDR_STAT;
    wire logic hit_cmd = paddr == fprnu_pkg::FPRNU_ADDR_CMD;
    wire logic hit_opa = paddr == fprnu_pkg::FPRNU_ADDR_OPA;
    wire logic hit_opb = paddr == fprnu_pkg::FPRNU_ADDR_OPB;
    wire logic hit_pa = paddr == fprnu_pkg::FPRNU_ADDR_OPA_PTR;
    wire logic hit_pb = paddr == fprnu_pkg::FPRNU_ADDR_OPB_PTR;
    wire logic hit_xse = paddr == fprnu_pkg::FPRNU_ADDR_XSE;
    wire logic hit_xsig = paddr == fprnu_pkg::FPRNU_ADDR_XSIG;
    wire logic hit_r0 = paddr == fprnu_pkg::FPRNU_ADDR_RES0;
    wire logic hit_r1 = paddr == fprnu_pkg::FPRNU_ADDR_RES1;
    wire logic hit_r2 = paddr == fprnu_pkg::FPRNU_ADDR_RES2;
    wire logic hit_ep = paddr == fprnu_pkg::FPRNU_ADDR_EXC_PTR;
    wire logic addr_hit = hit_ctrl | hit_stat | hit_cmd | hit_opa | hit_opb | hit_pa
        | hit_pb | hit_xse | hit_xsig | hit_r0 | hit_r1 | hit_r2 | hit_ep;

    wire logic [2:0] cmd_op = pwdata[2:0];
    wire logic [1:0] cmd_fmt = pwdata[fprnu_pkg::FPRNU_CMD_FMT_LSB +: 2];
    wire logic cmd_fire = wr & hit_cmd;
    wire logic op_legal = cmd_op <= fprnu_pkg::FPRNU_OP_PROP;

    wire logic [31:0] ctrl_word = (32'(rnd_mode) << fprnu_pkg::FPRNU_CTRL_RND_LSB)
        | (32'(inv_mask) << fprnu_pkg::FPRNU_CTRL_INV_MASK);
    wire logic [31:0] stat_word = (32'(inexact_flag) << fprnu_pkg::FPRNU_STAT_INEXACT)
        | (32'(inv_flag) << fprnu_pkg::FPRNU_STAT_INV);
    wire logic [31:0] rd_word = hit_ctrl ? ctrl_word : hit_stat ? stat_word
        : hit_opa ? opa : hit_opb ? opb : hit_pa ? opa_addr : hit_pb ? opb_addr
        : hit_xse ? {23'h0, exact_se} : hit_xsig ? exact_sig
        : hit_r0 ? res[31:0] : hit_r1 ? res[63:32] : hit_r2 ? {16'h0, res[79:64]}
        : hit_ep ? exc_ptr : 32'h0;

    assign pready = 1'b1;
    assign pslverr = acc & ~addr_hit;

    // ------------------------------------------------------------
    // Operand classes
    // ------------------------------------------------------------
    wire fprnu_pkg::fprnu_sp_t a_sp = opa;
    wire fprnu_pkg::fprnu_sp_t b_sp = opb;
    wire fprnu_pkg::fprnu_hp_t a_hp = opa[15:0];
    // Payload is never inspected beyond nonzero and the quiet bit
    wire logic a_nan = fprnu_pkg::fprnu_sp_nan(a_sp);
    wire logic b_nan = fprnu_pkg::fprnu_sp_nan(b_sp);
    wire logic a_snan = fprnu_pkg::fprnu_sp_snan(a_sp);
    wire logic b_snan = fprnu_pkg::fprnu_sp_snan(b_sp);
    wire logic a_inf = (a_sp.exp == fprnu_pkg::FPRNU_SP_EXP_MAX) & ~a_nan;
    wire logic a_zero = a_sp.exp == 8'h00;
    wire logic h_max = a_hp.exp == fprnu_pkg::FPRNU_HP_EXP_MAX;
    wire logic h_nan = h_max & (a_hp.frac != 10'h0);
    wire logic h_snan = h_nan & ~a_hp.frac[9];

    // ------------------------------------------------------------
    // Rounding of the exact result to single
    // ------------------------------------------------------------
    // Exact value: hidden bit 31, kept fraction 30:8, guard 7, sticky 6:0
    wire logic x_special = exact_se[7:0] == fprnu_pkg::FPRNU_SP_EXP_MAX;
    wire logic x_sticky = |exact_sig[6:0];
    logic [24:0] rs;
    logic rs_lost;

    fprnu_round #(
        .W(fprnu_pkg::FPRNU_SP_SIG_W)
    ) u_round_sp (
        .sig_in(exact_sig[31:8]),
        .guard(exact_sig[7]),
        .sticky(x_sticky),
        .sign(exact_se[8]),
        .mode(rnd_mode),
        .sig_out(rs),
        .inexact(rs_lost)
    );

    // A carry out renormalises to 1.000 with the next exponent
    wire logic [7:0] rs_exp = exact_se[7:0] + {7'h0, rs[24]};
    wire logic [22:0] rs_frac = rs[24] ? rs[23:1] : rs[22:0];
    // NaN and infinity inputs pass untouched
    wire logic [31:0] rnd_word = x_special ? {exact_se, exact_sig[30:8]}
        : {exact_se[8], rs_exp, rs_frac};
    wire logic rnd_inexact = rs_lost & ~x_special;

    // ------------------------------------------------------------
    // Half conversions
    // ------------------------------------------------------------
    // Only conversions exist for half; no half arithmetic
    logic [11:0] hs;
    logic hs_lost;

    fprnu_round #(
        .W(fprnu_pkg::FPRNU_HP_SIG_W)
    ) u_round_hp (
        .sig_in({1'b1, a_sp.frac[22:13]}),
        .guard(a_sp.frac[12]),
        .sticky(|a_sp.frac[11:0]),
        .sign(a_sp.sign),
        .mode(rnd_mode),
        .sig_out(hs),
        .inexact(hs_lost)
    );

    // Limitation: out-of-range exponents wrap and subnormals flush to zero
    wire logic [7:0] s2h_exp8 = a_sp.exp - fprnu_pkg::FPRNU_EXP_REBIAS;
    wire logic [4:0] s2h_exp = s2h_exp8[4:0] + {4'h0, hs[11]};
    wire logic [9:0] s2h_frac = hs[11] ? hs[10:1] : hs[9:0];
    wire logic [15:0] s2h_word = a_nan ? {a_sp.sign, 5'h1f, 1'b1, a_sp.frac[21:13]}
        : a_inf ? {a_sp.sign, 15'h7c00}
        : a_zero ? {a_sp.sign, 15'h0}
        : {a_sp.sign, s2h_exp, s2h_frac};
    wire logic s2h_inexact = hs_lost & ~(a_nan | a_inf | a_zero);

    wire logic [7:0] h2s_exp = {3'h0, a_hp.exp} + fprnu_pkg::FPRNU_EXP_REBIAS;
    wire logic [9:0] h2s_nfrac = a_hp.frac | (h_nan ? fprnu_pkg::FPRNU_HP_QUIET_MASK : 10'h0);
    wire logic [31:0] h2s_word = h_max ? {a_hp.sign, 8'hff, h2s_nfrac, 13'h0}
        : (a_hp.exp == 5'h0) ? {a_hp.sign, 31'h0}
        : {a_hp.sign, h2s_exp, a_hp.frac, 13'h0};

    // ------------------------------------------------------------
    // Compare and NaN propagation
    // ------------------------------------------------------------
    wire logic [30:0] a_mag = opa[30:0];
    wire logic [30:0] b_mag = opb[30:0];
    wire logic both_zero = (a_mag == 31'h0) & (b_mag == 31'h0);
    wire logic cmp_eq = both_zero | (opa == opb);
    wire logic cmp_lt = (a_sp.sign != b_sp.sign) ? a_sp.sign
        : (a_sp.sign ? (a_mag > b_mag) : (a_mag < b_mag));
    // Result ignores the rounding field entirely
    wire logic [1:0] cmp_code = (a_nan | b_nan) ? fprnu_pkg::FPRNU_CMP_UN
        : cmp_eq ? fprnu_pkg::FPRNU_CMP_EQ
        : cmp_lt ? fprnu_pkg::FPRNU_CMP_LT : fprnu_pkg::FPRNU_CMP_GT;

    // First operand wins, quieted by setting its top fraction bit
    wire logic [31:0] nan_word = a_nan ? (opa | fprnu_pkg::FPRNU_SP_QUIET_MASK)
        : (opb | fprnu_pkg::FPRNU_SP_QUIET_MASK);
    wire logic [79:0] indef = (cmd_fmt == fprnu_pkg::FPRNU_FMT_DP)
        ? {16'h0, fprnu_pkg::FPRNU_INDEF_DP}
        : (cmd_fmt == fprnu_pkg::FPRNU_FMT_EP) ? fprnu_pkg::FPRNU_INDEF_EP
        : {48'h0, fprnu_pkg::FPRNU_INDEF_SP};
    wire logic [79:0] prop_res = (a_nan | b_nan) ? {48'h0, nan_word} : indef;

    // ------------------------------------------------------------
    // Exceptions
    // ------------------------------------------------------------
    wire logic uses_b = (cmd_op == fprnu_pkg::FPRNU_OP_CMP)
        | (cmd_op == fprnu_pkg::FPRNU_OP_PROP);
    wire logic snan_a = (cmd_op == fprnu_pkg::FPRNU_OP_H2S) ? h_snan
        : (cmd_op != fprnu_pkg::FPRNU_OP_ROUND) & a_snan;
    wire logic snan_b = uses_b & b_snan;
    wire logic trap_cond = (snan_a | snan_b) & ~inv_mask;
    wire logic trap_now = cmd_fire & op_legal & trap_cond;
    wire logic no_nan_prop = (cmd_op == fprnu_pkg::FPRNU_OP_PROP) & ~a_nan & ~b_nan;
    wire logic inv_now = cmd_fire & op_legal & (snan_a | snan_b | no_nan_prop);
    wire logic inexact_now = cmd_fire & (((cmd_op == fprnu_pkg::FPRNU_OP_ROUND) & rnd_inexact)
        | ((cmd_op == fprnu_pkg::FPRNU_OP_S2H) & s2h_inexact));
    wire logic res_wr = cmd_fire & op_legal & ~trap_cond;
    wire logic dest_wr = res_wr & (cmd_op != fprnu_pkg::FPRNU_OP_CMP);

    always_comb begin
        case (cmd_op)
            fprnu_pkg::FPRNU_OP_ROUND: next_res = {48'h0, rnd_word};
            fprnu_pkg::FPRNU_OP_CMP: next_res = {78'h0, cmp_code};
            fprnu_pkg::FPRNU_OP_H2S: next_res = {48'h0, h2s_word};
            fprnu_pkg::FPRNU_OP_S2H: next_res = {64'h0, s2h_word};
            fprnu_pkg::FPRNU_OP_PROP: next_res = prop_res;
            default: next_res = res;
        endcase
    end

    // ------------------------------------------------------------
    // Sequential state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rnd_mode <= fprnu_pkg::FPRNU_RESET_RND;
            inv_mask <= fprnu_pkg::FPRNU_RESET_INV_MASK;
        end else if (wr & hit_ctrl) begin
            rnd_mode <= pwdata[fprnu_pkg::FPRNU_CTRL_RND_LSB +: 2];
            inv_mask <= pwdata[fprnu_pkg::FPRNU_CTRL_INV_MASK];
        end
    end

    // Write one to clear; a new event in the same cycle wins
    wire logic clr_inv = wr & hit_stat & pwdata[fprnu_pkg::FPRNU_STAT_INV];
    wire logic clr_inx = wr & hit_stat & pwdata[fprnu_pkg::FPRNU_STAT_INEXACT];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            inv_flag <= 1'b0;
            inexact_flag <= 1'b0;
        end else begin
            inv_flag <= inv_now | (inv_flag & ~clr_inv);
            inexact_flag <= inexact_now | (inexact_flag & ~clr_inx);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            opa <= 32'h0;
        end else if (wr & hit_opa) begin
            opa <= pwdata;
        end else if (dest_wr) begin
            opa <= next_res[31:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            opb <= 32'h0;
            opa_addr <= 32'h0;
            opb_addr <= 32'h0;
            exact_se <= 9'h0;
            exact_sig <= 32'h0;
        end else begin
            opb <= (wr & hit_opb) ? pwdata : opb;
            opa_addr <= (wr & hit_pa) ? pwdata : opa_addr;
            opb_addr <= (wr & hit_pb) ? pwdata : opb_addr;
            exact_se <= (wr & hit_xse) ? pwdata[8:0] : exact_se;
            exact_sig <= (wr & hit_xsig) ? pwdata : exact_sig;
        end
    end

    // A trap leaves result and operands unaltered
    always_ff @(posedge core_clk) begin
        if (rst) begin
            res <= 80'h0;
            exc_ptr <= 32'h0;
            fp_trap <= 1'b0;
            prdata <= 32'h0;
        end else begin
            res <= res_wr ? next_res : res;
            exc_ptr <= trap_now ? (snan_a ? opa_addr : opb_addr) : exc_ptr;
            fp_trap <= trap_now;
            prdata <= (psel & ~penable) ? rd_word : prdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    wire logic rnd_cmd = cmd_fire & (cmd_op == fprnu_pkg::FPRNU_OP_ROUND) & ~x_special;
    wire logic frac_full = &exact_sig[30:8];

    AST_RNE_TIE: assert property (rnd_cmd && rnd_mode == fprnu_pkg::FPRNU_RND_NEAREST
        && exact_sig[7] && !x_sticky && !exact_sig[8]
        |=> res[22:0] == $past(exact_sig[30:8]))
        else $error("tie did not round to even");

    AST_RDOWN_NEG: assert property (rnd_cmd && rnd_mode == fprnu_pkg::FPRNU_RND_DOWN
        && exact_se[8] && exact_sig[7:0] != 8'h0 && !frac_full
        |=> res[22:0] == $past(exact_sig[30:8]) + 23'h1)
        else $error("round down of negative value not toward minus infinity");

    AST_RUP_NEG: assert property (rnd_cmd && rnd_mode == fprnu_pkg::FPRNU_RND_UP
        && exact_se[8] |=> res[22:0] == $past(exact_sig[30:8]))
        else $error("round up of negative value moved away from zero");

    AST_RTZ: assert property (rnd_cmd && rnd_mode == fprnu_pkg::FPRNU_RND_TRUNC
        |=> res[22:0] == $past(exact_sig[30:8]) && res[30:23] == $past(exact_se[7:0]))
        else $error("truncation changed the kept bits");

    AST_INEXACT_SET: assert property (rnd_cmd && exact_sig[7:0] != 8'h0
        |=> inexact_flag)
        else $error("inexact flag not set after lost bits");

    AST_EXACT_PASS: assert property (rnd_cmd && exact_sig[7:0] == 8'h0
        |=> res[31:0] == {$past(exact_se), $past(exact_sig[30:8])}
        && inexact_flag == $past(inexact_flag))
        else $error("exact result altered by rounding");

    AST_RND_DEFAULT: assert property ($past(rst)
        |-> rnd_mode == fprnu_pkg::FPRNU_RND_NEAREST)
        else $error("rounding mode not nearest after reset");

    AST_TRAP_ADDR: assert property (trap_now
        |=> fp_trap && res == $past(res)
        && exc_ptr == ($past(snan_a) ? $past(opa_addr) : $past(opb_addr)))
        else $error("trap did not record the operand address");

    AST_QUIET_A: assert property (cmd_fire && cmd_op == fprnu_pkg::FPRNU_OP_PROP
        && a_nan && inv_mask
        |=> res[31:0] == ($past(opa) | fprnu_pkg::FPRNU_SP_QUIET_MASK) && opa == res[31:0])
        else $error("first NaN operand not quieted into the destination");

    AST_INDEF_SP: assert property (cmd_fire && cmd_op == fprnu_pkg::FPRNU_OP_PROP
        && !a_nan && !b_nan && cmd_fmt == fprnu_pkg::FPRNU_FMT_SP
        |=> res[31:0] == fprnu_pkg::FPRNU_INDEF_SP && inv_flag)
        else $error("indefinite not delivered");

endmodule : fprnu_top

// ==== bench/fprnu_top_tb.sv ====
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
end
module fprnu_top_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fp_trap;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int comparisons = 0;

    always #50 core_clk = ~core_clk;

    fprnu_top dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fp_trap(fp_trap));

    // ------------------------------------------------------------
    // Bus access and reference rounding
    // ------------------------------------------------------------
    // Request held until pready is seen high; hangs are left to the watchdog
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask : rchk

    task automatic cmd(input logic [2:0] op, input logic [1:0] fmt);
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_CMD, {26'h0, fmt, 1'b0, op});
    endtask : cmd

    task automatic opnd(input logic [31:0] a, input logic [31:0] b);
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_OPA, a);
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_OPB, b);
    endtask : opnd

    // Returns {inexact, result}; exponent 0xff passes through untouched
    function automatic logic [32:0] ref_round(logic s, logic [7:0] ex, logic [31:0] sg,
        logic [1:0] m);
        logic gs;
        logic inc;
        logic [24:0] sum;
        gs = sg[7] | (|sg[6:0]);
        if (ex == 8'hff) return {1'b0, s, ex, sg[30:8]};
        case (m)
            2'h0: inc = sg[7] & ((|sg[6:0]) | sg[8]);
            2'h1: inc = s & gs;
            2'h2: inc = !s & gs;
            default: inc = 1'b0;
        endcase
        sum = {1'b0, sg[31:8]} + {24'h0, inc};
        if (sum[24]) return {gs, s, ex + 8'h01, 23'h0};
        return {gs, s, ex, sum[22:0]};
    endfunction : ref_round

    task automatic do_round(input logic s, input logic [7:0] ex, input logic [31:0] sg);
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_XSE, {23'h0, s, ex});
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_XSIG, sg);
        cmd(fprnu_pkg::FPRNU_OP_ROUND, fprnu_pkg::FPRNU_FMT_SP);
    endtask : do_round

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset();
        rchk(fprnu_pkg::FPRNU_ADDR_CTRL, 32'h0000_0080, "ctrl reset");
        rchk(fprnu_pkg::FPRNU_ADDR_STAT, 32'h0, "stat reset");
        do_round(1'b0, 8'h85, 32'h8000_0180);
        rchk(fprnu_pkg::FPRNU_ADDR_RES0, 32'h4280_0002, "default mode");
        rchk(8'h3c, 32'h0, "unmapped data");
        `CHK("unmapped err", 1'b1, err)
        `CHK("ready", 1'b1, pready)
        $display("test reset done");
    endtask : test_reset

    // Ties of both parities, carry-out and a NaN-exponent input, in every mode
    task automatic test_round();
        logic [31:0] sg [7] = '{32'h8000_0080, 32'h8000_0180, 32'h8000_0040,
            32'h8000_00c1, 32'hffff_ffff, 32'h8000_0100, 32'hc000_0011};
        logic [32:0] e;
        logic [7:0] ex;
        logic acc;
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, fprnu_pkg::FPRNU_ADDR_CTRL, {17'h0, m[1:0], 13'h0080});
            apb(1'b1, fprnu_pkg::FPRNU_ADDR_STAT, 32'h0000_0021);
            acc = 1'b0;
            for (int i = 0; i < 14; i++) begin
                ex = (i / 2 == 6) ? 8'hff : 8'h85;
                e = ref_round(i[0], ex, sg[i / 2], m[1:0]);
                acc = acc | e[32];
                do_round(i[0], ex, sg[i / 2]);
                rchk(fprnu_pkg::FPRNU_ADDR_RES0, e[31:0], "rounded");
                rchk(fprnu_pkg::FPRNU_ADDR_OPA, e[31:0], "destination");
                apb(1'b0, fprnu_pkg::FPRNU_ADDR_STAT, 32'h0);
                `CHK("inexact", acc, rd[5])
            end
        end
        $display("test round done");
    endtask : test_round

    task automatic test_cmp();
        logic [31:0] a [4] = '{32'h3f80_0000, 32'h4000_0000, 32'h0, 32'h7fc0_0000};
        logic [31:0] b [4] = '{32'h4000_0000, 32'h3f80_0000, 32'h8000_0000, 32'h3f80_0000};
        logic [1:0] r [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_CTRL, 32'h0000_6080);
        for (int i = 0; i < 4; i++) begin
            opnd(a[i], b[i]);
            cmd(fprnu_pkg::FPRNU_OP_CMP, fprnu_pkg::FPRNU_FMT_SP);
            apb(1'b0, fprnu_pkg::FPRNU_ADDR_RES0, 32'h0);
            `CHK("compare", r[i], rd[1:0])
            rchk(fprnu_pkg::FPRNU_ADDR_OPA, a[i], "compare keeps dest");
        end
        $display("test compare done");
    endtask : test_cmp

    // Masked invalid: quieting, payload kept, indefinite per format
    task automatic test_nan();
        logic [31:0] a [3] = '{32'h7f80_0005, 32'h3f80_0000, 32'h7fd5_5555};
        logic [31:0] b [3] = '{32'h3f80_0000, 32'hffa1_2345, 32'h7f80_0001};
        logic [31:0] r [3] = '{32'h7fc0_0005, 32'hffe1_2345, 32'h7fd5_5555};
        logic [79:0] ind [3] = '{{48'h0, fprnu_pkg::FPRNU_INDEF_SP},
            {16'h0, fprnu_pkg::FPRNU_INDEF_DP}, fprnu_pkg::FPRNU_INDEF_EP};
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_CTRL, 32'h0000_4080);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, fprnu_pkg::FPRNU_ADDR_STAT, 32'h0000_0021);
            opnd(a[i], b[i]);
            cmd(fprnu_pkg::FPRNU_OP_PROP, fprnu_pkg::FPRNU_FMT_SP);
            rchk(fprnu_pkg::FPRNU_ADDR_RES0, r[i], "nan result");
            rchk(fprnu_pkg::FPRNU_ADDR_STAT, 32'h0000_0001, "invalid flag");
        end
        for (int f = 0; f < 3; f++) begin
            opnd(32'h3f80_0000, 32'h4000_0000);
            cmd(fprnu_pkg::FPRNU_OP_PROP, f[1:0]);
            rchk(fprnu_pkg::FPRNU_ADDR_RES0, ind[f][31:0], "indef low");
            if (f > 0) rchk(fprnu_pkg::FPRNU_ADDR_RES1, ind[f][63:32], "indef mid");
            apb(1'b0, fprnu_pkg::FPRNU_ADDR_RES2, 32'h0);
            if (f == 2) `CHK("indef top", ind[f][79:64], rd[15:0])
        end
        $display("test nan done");
    endtask : test_nan

    task automatic test_trap();
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_CTRL, 32'h0);
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_OPA_PTR, 32'h1000_0040);
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_OPB_PTR, 32'h2000_0080);
        for (int i = 0; i < 2; i++) begin
            opnd(i ? 32'h3f80_0000 : 32'h7f80_0001, i ? 32'h7f80_0001 : 32'h3f80_0000);
            cmd(i ? fprnu_pkg::FPRNU_OP_CMP : fprnu_pkg::FPRNU_OP_PROP, 2'h0);
            @(posedge core_clk);
            `CHK("trap high", 1'b1, fp_trap)
            @(posedge core_clk);
            `CHK("trap low", 1'b0, fp_trap)
            rchk(fprnu_pkg::FPRNU_ADDR_EXC_PTR, i ? 32'h2000_0080 : 32'h1000_0040,
                "exc pointer");
            rchk(fprnu_pkg::FPRNU_ADDR_OPA, i ? 32'h3f80_0000 : 32'h7f80_0001,
                "dest kept");
        end
        $display("test trap done");
    endtask : test_trap

    task automatic test_half();
        logic [15:0] h [4] = '{16'h3c00, 16'h3c00, 16'h3c01, 16'h3c00};
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_CTRL, 32'h0000_0080);
        opnd(32'h0000_3c00, 32'h0);
        cmd(fprnu_pkg::FPRNU_OP_H2S, 2'h0);
        rchk(fprnu_pkg::FPRNU_ADDR_RES0, 32'h3f80_0000, "half to single");
        opnd(32'h0000_7c01, 32'h0);
        cmd(fprnu_pkg::FPRNU_OP_H2S, 2'h0);
        rchk(fprnu_pkg::FPRNU_ADDR_RES0, 32'h7fc0_2000, "half nan");
        apb(1'b1, fprnu_pkg::FPRNU_ADDR_STAT, 32'h0000_0021);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, fprnu_pkg::FPRNU_ADDR_CTRL, {17'h0, m[1:0], 13'h0080});
            opnd(32'h3f80_1000, 32'h0);
            cmd(fprnu_pkg::FPRNU_OP_S2H, 2'h0);
            apb(1'b0, fprnu_pkg::FPRNU_ADDR_RES0, 32'h0);
            `CHK("single to half", h[m], rd[15:0])
        end
        rchk(fprnu_pkg::FPRNU_ADDR_STAT, 32'h0000_0020, "half inexact");
        $display("test half done");
    endtask : test_half

    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        test_reset();
        test_round();
        test_cmp();
        test_nan();
        test_trap();
        test_half();
        end_of_test();
    end
endmodule : fprnu_top_tb
